// ---- core/pto_top.sv ----
/*
  Trigger output control: done/arm/soft-reset bits for twelve units, unit 1
  target time compare with skew delay, unit 12 pulse-per-second width.
  Assumes a synchronous single-clock register port and a system time that
  is synchronous to CORE_CLK; units 2 to 12 report their hits on UNIT_HIT.
*/
// Design decision made here: strobed register access.
// Functional notes
// - Notified trigger sets done bit; write-one clears
// - Done bit interrupts host when enable set
// - Twelve unit bits, bit 0 is unit 1
// - Arm bit arms unit, self-clears on output
// - Soft reset idles unit, self-clears
// - Three-bit skew delays unit 1 output
// - Unit 12 width is upper byte plus word
// - Unit 1 nanosecond low word, reset zero
// - Nanosecond high word bits 13-0, rest reserved
// - Unit 1 seconds low word, reset zero
// - Unit 1 seconds high word, 32-bit seconds
// - Report enable gates done and interrupt
module pto_top (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic [pto_pkg::ADDR_W-1:0] ADDR,
  input wire logic [pto_pkg::DATA_W-1:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [pto_pkg::DATA_W-1:0] RD_DATA,
  input wire logic [29:0] SYS_NSEC,
  input wire logic [31:0] SYS_SEC,
  input wire logic [pto_pkg::UNITS-1:1] UNIT_HIT,
  output logic [pto_pkg::UNITS-1:0] TRIG_OUT,
  output logic UNIT12_PPS,
  output logic IRQ
);
  import pto_pkg::*;

  function automatic logic [1:0] skew_cycles(input logic [2:0] f, input logic fine);
    logic [5:0] ns;
    ns = fine ? 6'(f * SKEW_FINE_NS) : 6'(f * SKEW_COARSE_NS);
    skew_cycles = 2'((ns + 6'(CLK_PERIOD_NS - 1)) / 6'(CLK_PERIOD_NS));
  endfunction

  logic [11:0] done_q, done_d;
  logic [11:0] arm_q, arm_d;
  logic [11:0] srst_q;
  logic [11:0] report_q;
  logic [11:0] irqen_q;
  logic [11:0] u12w_q;
  logic [15:0] u12cfg2_q;
  logic [15:0] nsl_q;
  logic [NSH_W-1:0] nsh_q;
  logic [15:0] sl_q;
  logic [15:0] sh_q;
  logic [15:0] rd_data_q;
  logic [11:0] trig_q;
  logic irq_q;
  logic pps_q;
  logic [26:0] pps_cnt_q;
  logic [1:0] dly_q;
  pto_u1_e u1_q, u1_d;

  wire wr_done = WR_STB && (ADDR == OFS_DONE);
  wire wr_arm = WR_STB && (ADDR == OFS_ARM);
  wire wr_srst = WR_STB && (ADDR == OFS_SRST);
  wire wr_u12w = WR_STB && (ADDR == OFS_U12W);
  wire wr_nsl = WR_STB && (ADDR == OFS_NSL);
  wire wr_nsh = WR_STB && (ADDR == OFS_NSH);
  wire wr_sl = WR_STB && (ADDR == OFS_SL);
  wire wr_sh = WR_STB && (ADDR == OFS_SH);
  wire wr_report = WR_STB && (ADDR == OFS_REPORT);
  wire wr_irqen = WR_STB && (ADDR == OFS_IRQEN);
  wire wr_u12cfg2 = WR_STB && (ADDR == OFS_U12CFG2);
  wire [11:0] wr_bits = WR_DATA[11:0];
  // Soft reset takes effect in the write cycle itself
  wire [11:0] srst_now = wr_srst ? wr_bits : 12'h000;

  // Unit 1 compare against the running system time
  wire [61:0] target_time = {sh_q, sl_q, nsh_q, nsl_q};
  wire [61:0] sys_time = {SYS_SEC, SYS_NSEC};
  wire u1_reached = sys_time >= target_time;
  wire [2:0] skew_field = u12w_q[SKEW_LSB+2:SKEW_LSB];
  wire skew_fine = u12w_q[SKEW_RANGE_BIT];
  wire [1:0] skew_cyc = skew_cycles(skew_field, skew_fine);
  wire u1_live = arm_q[0] && !srst_now[0];
  logic u1_fire;

  always_comb begin
    u1_d = u1_q;
    u1_fire = 1'b0;
    case (u1_q)
      PTO_IDLE: begin
        if (u1_live) begin
          u1_d = PTO_ARMED;
        end
      end
      PTO_ARMED: begin
        if (!u1_live) begin
          u1_d = PTO_IDLE;
        end else if (u1_reached && skew_cyc == 2'd0) begin
          u1_fire = 1'b1;
          u1_d = PTO_IDLE;
        end else if (u1_reached) begin
          u1_d = PTO_DELAY;
        end
      end
      PTO_DELAY: begin
        if (!u1_live) begin
          u1_d = PTO_IDLE;
        end else if (dly_q == 2'd1) begin
          u1_fire = 1'b1;
          u1_d = PTO_IDLE;
        end
      end
      default: begin
        u1_d = PTO_IDLE;
      end
    endcase
  end

  // Other units only count while armed; a stray hit on a disarmed unit is dropped
  wire [11:1] hit_ok = UNIT_HIT & arm_q[11:1] & ~srst_now[11:1];
  wire [11:0] fire = {hit_ok, u1_fire};

  // Hardware set beats software clear, so no event is lost
  always_comb begin
    done_d = done_q;
    if (wr_done) begin
      done_d = done_q & ~wr_bits;
    end
    done_d = (done_d | (fire & report_q)) & ~srst_now;
  end

  always_comb begin
    arm_d = wr_arm ? wr_bits : arm_q;
    arm_d = arm_d & ~fire & ~srst_now;
  end

  wire [26:0] pps_width_ns = 27'({u12w_q[PPS_UPPER_LSB+7:PPS_UPPER_LSB], u12cfg2_q}
    * PPS_STEP_NS);

  wire [15:0] rd_mux =
    (ADDR == OFS_DONE) ? {4'h0, done_q} :
    (ADDR == OFS_ARM) ? {4'h0, arm_q} :
    (ADDR == OFS_SRST) ? {4'h0, srst_q} :
    (ADDR == OFS_U12W) ? {4'h0, u12w_q} :
    (ADDR == OFS_NSL) ? nsl_q :
    (ADDR == OFS_NSH) ? {2'b00, nsh_q} :
    (ADDR == OFS_SL) ? sl_q :
    (ADDR == OFS_SH) ? sh_q :
    (ADDR == OFS_REPORT) ? {4'h0, report_q} :
    (ADDR == OFS_IRQEN) ? {4'h0, irqen_q} :
    (ADDR == OFS_U12CFG2) ? u12cfg2_q :
    16'h0000;

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      done_q <= RST_UNIT_BITS;
      arm_q <= RST_UNIT_BITS;
      srst_q <= RST_UNIT_BITS;
      u1_q <= PTO_IDLE;
      dly_q <= 2'd0;
      trig_q <= RST_UNIT_BITS;
      irq_q <= 1'b0;
    end else begin
      done_q <= done_d;
      arm_q <= arm_d;
      srst_q <= RST_UNIT_BITS;
      u1_q <= u1_d;
      dly_q <= (u1_d == PTO_DELAY && u1_q == PTO_ARMED) ? skew_cyc : dly_q - 2'd1;
      trig_q <= fire;
      irq_q <= |(done_d & irqen_q);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      nsl_q <= RST_WORD;
      nsh_q <= RST_WORD[NSH_W-1:0];
      sl_q <= RST_WORD;
      sh_q <= RST_WORD;
    end else begin
      if (wr_nsl) begin
        nsl_q <= WR_DATA;
      end
      if (wr_nsh) begin
        nsh_q <= WR_DATA[NSH_W-1:0];
      end
      if (wr_sl) begin
        sl_q <= WR_DATA;
      end
      if (wr_sh) begin
        sh_q <= WR_DATA;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      u12w_q <= RST_U12W;
      u12cfg2_q <= RST_WORD;
      report_q <= RST_UNIT_BITS;
      irqen_q <= RST_UNIT_BITS;
      rd_data_q <= RST_WORD;
    end else begin
      if (wr_u12w) begin
        u12w_q <= wr_bits;
      end else if (srst_now[0]) begin
        u12w_q[SKEW_RANGE_BIT:SKEW_LSB] <= RST_U12W[SKEW_RANGE_BIT:SKEW_LSB];
      end
      if (wr_u12cfg2) begin
        u12cfg2_q <= WR_DATA;
      end
      if (wr_report) begin
        report_q <= wr_bits & ~srst_now;
      end else begin
        report_q <= report_q & ~srst_now;
      end
      if (wr_irqen) begin
        irqen_q <= wr_bits;
      end
      rd_data_q <= RD_STB ? rd_mux : RST_WORD;
    end
  end

  // Width counted in ns so the 8 ns step needs no divider
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      pps_q <= 1'b0;
      pps_cnt_q <= 27'h0000000;
    end else if (srst_now[11]) begin
      pps_q <= 1'b0;
      pps_cnt_q <= 27'h0000000;
    end else if (fire[11] && pps_width_ns != 27'h0000000) begin
      pps_q <= 1'b1;
      pps_cnt_q <= PPS_TICK_NS;
    end else if (pps_q && pps_cnt_q >= pps_width_ns) begin
      pps_q <= 1'b0;
    end else if (pps_q) begin
      pps_cnt_q <= pps_cnt_q + PPS_TICK_NS;
    end
  end

  assign RD_DATA = rd_data_q;
  assign TRIG_OUT = trig_q;
  assign UNIT12_PPS = pps_q;
  assign IRQ = irq_q;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  sequence s_u1_reach_now;
    u1_q == PTO_ARMED && u1_live && u1_reached && skew_cyc == 2'd0;
  endsequence

  sequence s_u1_reach_late;
    u1_q == PTO_ARMED && u1_live && u1_reached && skew_cyc == 2'd2;
  endsequence

  sequence s_u1_abort;
    u1_q != PTO_IDLE && srst_now[0];
  endsequence

  chk_done_on_fire: assert property (
    (fire[0] && report_q[0]) |=> done_q[0])
    else $error("done bit not set on notified fire");

  chk_done_gated: assert property (
    (|(fire & ~report_q)) |=> (done_q & ~$past(done_q) & $past(fire & ~report_q)) == 12'h000)
    else $error("done bit set without notify");

  chk_done_w1c: assert property (
    wr_done |=> (done_q & $past(wr_bits) & ~$past(fire)) == 12'h000)
    else $error("done bit not cleared by write one");

  chk_irq_level: assert property (
    ##1 (IRQ == |($past(done_d) & $past(irqen_q))))
    else $error("interrupt does not follow masked done");

  chk_arm_selfclear: assert property (
    (|fire) |=> (arm_q & $past(fire)) == 12'h000 && TRIG_OUT == $past(fire))
    else $error("arm bit not cleared after trigger");

  chk_srst_clear: assert property (
    wr_srst |=> srst_q == 12'h000 && (arm_q & $past(wr_bits)) == 12'h000)
    else $error("soft reset did not idle unit");

  chk_u1_now: assert property (
    s_u1_reach_now |=> TRIG_OUT[0])
    else $error("unit 1 not fired at target");

  chk_u1_skew: assert property (
    s_u1_reach_late |=> !TRIG_OUT[0] ##1 !TRIG_OUT[0] ##1 TRIG_OUT[0])
    else $error("unit 1 skew delay wrong");

  chk_pps_width: assert property (
    (fire[11] && !srst_now[11] && u12cfg2_q == 16'h0003 && u12w_q[7:0] == 8'h00)
      |=> UNIT12_PPS [*3] ##1 !UNIT12_PPS)
    else $error("unit 12 pulse width wrong");

  chk_nsh_reserved: assert property (
    (RD_STB && ADDR == OFS_NSH) |=> RD_DATA[15:14] == 2'b00)
    else $error("reserved nsec high bits not zero");

  chk_sec_high: assert property (
    wr_sh |=> sh_q == $past(WR_DATA))
    else $error("seconds high word not stored");

  chk_arm_write: assert property (
    (wr_arm && fire == 12'h000 && srst_now == 12'h000) |=> arm_q == $past(wr_bits))
    else $error("arm bits not stored");

  chk_hit_unarmed: assert property (
    (UNIT_HIT[3] && !arm_q[3]) |=> !TRIG_OUT[3])
    else $error("disarmed unit produced output");

  chk_srst_report: assert property (
    wr_srst |=> (report_q & $past(wr_bits)) == 12'h000)
    else $error("soft reset left notify set");

  chk_srst_done: assert property (
    wr_srst |=> (done_q & $past(wr_bits)) == 12'h000)
    else $error("soft reset left done set");

  chk_u1_abort: assert property (
    s_u1_abort |=> !TRIG_OUT[0] ##1 !TRIG_OUT[0])
    else $error("unit 1 fired after soft reset");

  chk_pps_start: assert property (
    (fire[11] && !srst_now[11] && pps_width_ns != 27'h0000000) |=> UNIT12_PPS && TRIG_OUT[11])
    else $error("unit 12 pulse did not start");

  chk_nsl_store: assert property (
    wr_nsl |=> nsl_q == $past(WR_DATA))
    else $error("nanosecond low word not stored");

  chk_nsh_store: assert property (
    wr_nsh |=> nsh_q == $past(WR_DATA[13:0]))
    else $error("nanosecond high word not stored");

  chk_sl_store: assert property (
    wr_sl |=> sl_q == $past(WR_DATA))
    else $error("seconds low word not stored");
endmodule

// ---- shared/pto_pkg.sv ----
/*
  Shared constants for the trigger output control block: register offsets,
  field positions, reset values and timing figures.
  Assumes a 100 MHz core clock and 16-bit register data.
*/
package pto_pkg;
  localparam int unsigned UNITS = 12;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 16;

  localparam logic [9:0] OFS_DONE = 10'h204;
  localparam logic [9:0] OFS_ARM = 10'h206;
  localparam logic [9:0] OFS_SRST = 10'h208;
  localparam logic [9:0] OFS_U12W = 10'h20a;
  localparam logic [9:0] OFS_NSL = 10'h220;
  localparam logic [9:0] OFS_NSH = 10'h222;
  localparam logic [9:0] OFS_SL = 10'h224;
  localparam logic [9:0] OFS_SH = 10'h226;
  localparam logic [9:0] OFS_REPORT = 10'h240;
  localparam logic [9:0] OFS_IRQEN = 10'h242;
  localparam logic [9:0] OFS_U12CFG2 = 10'h38a;

  localparam int unsigned SKEW_RANGE_BIT = 11;
  localparam int unsigned SKEW_LSB = 8;
  localparam int unsigned PPS_UPPER_LSB = 0;
  localparam int unsigned NSH_W = 14;

  localparam logic [11:0] RST_UNIT_BITS = 12'h000;
  localparam logic [11:0] RST_U12W = 12'h000;
  localparam logic [15:0] RST_WORD = 16'h0000;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SKEW_FINE_NS = 1;
  localparam int unsigned SKEW_COARSE_NS = 4;
  localparam int unsigned PPS_STEP_NS = 8;
  localparam logic [26:0] PPS_TICK_NS = 27'(CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    PTO_IDLE = 2'b00,
    PTO_ARMED = 2'b01,
    PTO_DELAY = 2'b11
  } pto_u1_e;
endpackage

// ---- tb/tb_top.sv ----
/*
  Self-checking bench for the trigger output control block.
  Assumes pto_pkg and pto_top; drives register port, time and unit hits.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pto_pkg::*;
  `define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [15:0] wr_data = 16'h0000;
  logic [15:0] rdv;
  logic [29:0] sys_nsec = 30'h0;
  logic [31:0] sys_sec = 32'h0;
  logic [11:1] unit_hit = 11'h000;
  logic [15:0] rd_data;
  logic [11:0] trig_out;
  logic pps;
  logic irq;
  int errors = 0;
  int n_tests = 0;
  int cnt;
  // Register rows: offset, value written, value read back
  logic [9:0] ra[11] = '{OFS_NSL, OFS_NSH, OFS_SL, OFS_SH, OFS_U12W, OFS_U12CFG2,
    OFS_IRQEN, OFS_REPORT, OFS_DONE, OFS_SRST, 10'h20c};
  logic [15:0] rw[11] = '{16'hffff, 16'hffff, 16'ha5a5, 16'h5a5a, 16'hffff, 16'h1234,
    16'hffff, 16'hffff, 16'hffff, 16'h0000, 16'hffff};
  logic [15:0] rb[11] = '{16'hffff, 16'h3fff, 16'ha5a5, 16'h5a5a, 16'h0fff, 16'h1234,
    16'h0fff, 16'h0fff, 16'h0000, 16'h0000, 16'h0000};
  // Skew settings {range, field} and expected extra cycles
  logic [3:0] sk_t[6] = '{4'hf, 4'h7, 4'h5, 4'h1, 4'h0, 4'h8};
  int n_t[6] = '{1, 3, 2, 1, 0, 0};

  pto_top dut (.CORE_CLK(clk), .NRST(nrst), .ADDR(addr), .WR_DATA(wr_data),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data), .SYS_NSEC(sys_nsec),
    .SYS_SEC(sys_sec), .UNIT_HIT(unit_hit), .TRIG_OUT(trig_out),
    .UNIT12_PPS(pps), .IRQ(irq));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  // Read data only stands in the cycle after the strobe
  task automatic rchk(input logic [9:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    `CHK($sformatf("reg %h", a), e, rd_data)
  endtask

  task automatic hit(input int u, input logic e);
    @(posedge clk);
    unit_hit[u] <= 1'b1;
    @(posedge clk);
    unit_hit[u] <= 1'b0;
    #1;
    `CHK("hit out", e, trig_out[u])
  endtask

  task automatic fire_u1(input logic [3:0] sk, input int n);
    wr(OFS_U12W, {4'h0, sk, 8'h00});
    wr(OFS_ARM, 16'h0001);
    @(posedge clk);
    sys_nsec <= 30'h64;
    cnt = 0;
    do begin
      @(posedge clk);
      #1;
      cnt++;
    end while (trig_out[0] !== 1'b1 && cnt < 20);
    `CHK("u1 delay", n + 1, cnt)
    rchk(OFS_ARM, 16'h0000);
    rchk(OFS_DONE, 16'h0001);
    `CHK("irq set", 1'b1, irq)
    wr(OFS_DONE, 16'h0001);
    sys_nsec <= 30'h0;
    rchk(OFS_DONE, 16'h0000);
    `CHK("irq clr", 1'b0, irq)
  endtask

  task automatic final_report();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles
  initial begin
    #300us;
    errors++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("rst out", 14'h0, {trig_out, pps, irq})
    for (int i = 0; i < 11; i++) begin
      rchk(ra[i], 16'h0000);
    end
    for (int i = 0; i < 11; i++) begin
      wr(ra[i], rw[i]);
      rchk(ra[i], rb[i]);
    end
    wr(OFS_NSL, 16'h0064);
    wr(OFS_NSH, 16'h0000);
    wr(OFS_SL, 16'h0000);
    wr(OFS_SH, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      fire_u1(sk_t[i], n_t[i]);
    end
    // Masked interrupt, then unmasked
    wr(OFS_IRQEN, 16'h0000);
    wr(OFS_ARM, 16'h0002);
    hit(1, 1'b1);
    rchk(OFS_DONE, 16'h0002);
    `CHK("irq mask", 1'b0, irq)
    wr(OFS_IRQEN, 16'h0002);
    @(posedge clk);
    #1;
    `CHK("irq unmask", 1'b1, irq)
    wr(OFS_DONE, 16'h0002);
    // Hit on an unarmed unit gives nothing
    hit(3, 1'b0);
    // Soft reset drops the armed unit 1
    wr(OFS_ARM, 16'h0001);
    wr(OFS_SRST, 16'h0001);
    rchk(OFS_ARM, 16'h0000);
    rchk(OFS_SRST, 16'h0000);
    rchk(OFS_REPORT, 16'h0ffe);
    @(posedge clk);
    sys_nsec <= 30'h64;
    cnt = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      cnt += int'(trig_out[0] === 1'b1);
    end
    `CHK("srst fire", 0, cnt)
    @(posedge clk);
    sys_nsec <= 30'h0;
    // Unit 12 pulse of 3 steps of 8 ns
    wr(OFS_U12CFG2, 16'h0003);
    wr(OFS_U12W, 16'h0000);
    wr(OFS_ARM, 16'h0800);
    hit(11, 1'b1);
    cnt = 0;
    while (pps === 1'b1 && cnt < 50) begin
      cnt++;
      @(posedge clk);
      #1;
    end
    `CHK("pps width", 3, cnt)
    rchk(OFS_DONE, 16'h0800);
    // Reporting off: fire but no done bit
    wr(OFS_REPORT, 16'h0000);
    wr(OFS_ARM, 16'h0004);
    hit(2, 1'b1);
    rchk(OFS_DONE, 16'h0800);
    // Mid-run reset with a done bit and its interrupt standing
    wr(OFS_IRQEN, 16'h0800);
    @(posedge clk);
    #1;
    `CHK("irq pre", 1'b1, irq)
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("rst2 out", 14'h0, {trig_out, pps, irq})
    rchk(OFS_DONE, 16'h0000);
    rchk(OFS_IRQEN, 16'h0000);
    rchk(OFS_NSL, 16'h0000);
    final_report();
  end
endmodule
